// file: verilog/reset_cause_pkg.sv
package reset_cause_pkg;

  // APB side
  localparam int APB_ADDR_W = 16;
  localparam int APB_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [11:0] CAUSE_IDX = 12'hff0;
  localparam logic [11:0] RELOAD_UPPER_IDX = 12'hff1;
  localparam logic [11:0] RELOAD_MIDDLE_IDX = 12'hff2;
  localparam logic [11:0] RELOAD_LOWER_IDX = 12'hff3;

  // Cause nibble = register bits 7:4 {power_on, stop_recovery, watchdog_expiry_flag, external_pin_flag}
  localparam int CAUSE_LSB = 4;
  localparam int POWER_ON_BIT = 3;
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_POWER_ON = 4'h8;
  localparam logic [3:0] CAUSE_STOP = 4'h4;
  localparam logic [3:0] CAUSE_WDT = 4'h2;
  localparam logic [3:0] CAUSE_EXT = 4'h1;
  localparam logic [3:0] CAUSE_STOP_WDT = 4'h6;
  localparam logic [3:0] CAUSE_RESET = 4'h8;

  // Watchdog reload
  localparam int WDT_W = 24;
  localparam logic [23:0] RELOAD_RESET = 24'h000400;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b0;

  // Pin glitch filter timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PIN_MIN_PULSE_NS = 200;
  localparam int PIN_FILTER_CYCLES = (PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [3:0] cause;
    logic [23:0] count;
    logic [23:0] reload;
    logic wdt_en;
    logic [7:0] rdata;
    logic sys_reset;
    logic stop_rec;
  } wdt_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic [7:0] cnt;
    logic fall;
  } filt_state_t;

endpackage : reset_cause_pkg

// file: verilog/pin_glitch_filter.sv
`timescale 1ns/1ps
module pin_glitch_filter #(
  parameter int FILTER_CYCLES = reset_cause_pkg::PIN_FILTER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_n,
  output logic level_n,
  output logic fall
);

  if (FILTER_CYCLES < 1 || FILTER_CYCLES > 255) begin : g_bad_cycles
    $error("pin_glitch_filter: FILTER_CYCLES must be 1 to 255");
  end

  localparam logic [7:0] LAST = 8'(FILTER_CYCLES - 1);

  reset_cause_pkg::filt_state_t st_reg;
  reset_cause_pkg::filt_state_t st_next;

  // A new level is taken only after it has been seen for FILTER_CYCLES samples in a row
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_n;
    st_next.s2 = st_reg.s1;
    st_next.fall = 1'b0;
    if (st_reg.s2 == st_reg.level) begin
      st_next.cnt = 8'h00;
    end else if (st_reg.cnt == LAST) begin
      st_next.cnt = 8'h00;
      st_next.level = st_reg.s2;
      st_next.fall = ~st_reg.s2;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: 8'h00, fall: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_n = st_reg.level;
  assign fall = st_reg.fall;

  chk_fall_needs_low: assert property (@(posedge sys_clk) disable iff (rst)
    fall |-> $past(st_reg.s2) == 1'b0) else $error("filter fall without a low sample");

endmodule : pin_glitch_filter

// file: verilog/reset_cause_and_watchdog_reload.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - External reset pin low during stop gives full system reset, not stop recovery.
// - Reset pin is glitch filtered; short low pulses are ignored.
// - Read-only reset cause register at index ff0 reports the latest reset source.
// - Reading the cause register returns flags, then clears the four flag bits.
// - Reads at ff0 give cause flags; writes there go to watchdog control.
// - Power-on, debug control bit 1, debug pin low in stop set power-on only.
// - External pin reset sets only the external pin flag, bit 4.
// - Watchdog expiry in normal operation sets only the watchdog flag, bit 5.
// - Port pin stop recovery sets only the stop recovery flag, bit 6.
// - Watchdog expiry in stop sets stop recovery and watchdog flags together.
// - Power-on flag clears on later watchdog expiry, stop recovery, or read.
// - 24-bit reload split over bytes at ff1, ff2, ff3, upper to lower.
// - Reload byte reads return live count byte; writes set the reload byte.
module reset_cause_and_watchdog_reload #(
  parameter int FILTER_CYCLES = reset_cause_pkg::PIN_FILTER_CYCLES,
  parameter int WDT_WIDTH = reset_cause_pkg::WDT_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [reset_cause_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [reset_cause_pkg::APB_DATA_W-1:0] pwdata,
  output logic [reset_cause_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_reset_n,
  input wire logic debug_pin_n,
  input wire logic debug_reset_req,
  input wire logic stop_mode,
  input wire logic gpio_wake,
  output logic system_reset_out,
  output logic stop_recovery_out,
  output logic watchdog_expired
);

  if (WDT_WIDTH != 24) begin : g_bad_width
    $error("reset_cause_and_watchdog_reload: reload is three bytes, WDT_WIDTH must be 24");
  end

  reset_cause_pkg::wdt_state_t st_reg;
  reset_cause_pkg::wdt_state_t st_next;

  logic ext_fall;
  logic dbg_fall;
  logic [11:0] idx;
  logic word_ok;
  logic hit_cause;
  logic hit_upper;
  logic hit_middle;
  logic hit_lower;
  logic mapped;
  logic setup_phase;
  logic access_phase;
  logic rd_access;
  logic wr_access;
  logic wdt_expire;
  logic evt_any;
  logic evt_full;
  logic evt_stop;
  logic [3:0] evt_cause;
  logic [7:0] rd_mux;

  // Both pins are asynchronous; each is synchronised and filtered before use
  pin_glitch_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_ext_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_n(ext_reset_n),
    .level_n(),
    .fall(ext_fall)
  );

  pin_glitch_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_dbg_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_n(debug_pin_n),
    .level_n(),
    .fall(dbg_fall)
  );

  // Address decode: one aligned word per register
  assign idx = paddr[13:2];
  assign word_ok = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);
  assign hit_cause = word_ok && (idx == reset_cause_pkg::CAUSE_IDX);
  assign hit_upper = word_ok && (idx == reset_cause_pkg::RELOAD_UPPER_IDX);
  assign hit_middle = word_ok && (idx == reset_cause_pkg::RELOAD_MIDDLE_IDX);
  assign hit_lower = word_ok && (idx == reset_cause_pkg::RELOAD_LOWER_IDX);
  assign mapped = hit_cause | hit_upper | hit_middle | hit_lower;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign rd_access = access_phase & ~pwrite & mapped;
  assign wr_access = access_phase & pwrite & mapped;

  // Zero wait state slave; read data is sampled in setup so it comes from a flop
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;
  assign prdata = {24'h000000, st_reg.rdata};

  // Read mux: cause in the high nibble, live count bytes for the reload addresses
  always_comb begin
    rd_mux = 8'h00;
    if (hit_cause) begin
      rd_mux = {st_reg.cause, 4'h0};
    end else if (hit_upper) begin
      rd_mux = st_reg.count[23:16];
    end else if (hit_middle) begin
      rd_mux = st_reg.count[15:8];
    end else if (hit_lower) begin
      rd_mux = st_reg.count[7:0];
    end
  end

  assign wdt_expire = st_reg.wdt_en && (st_reg.count == 24'h000000);

  // One event is recorded per cycle; the priority is pin, debug, watchdog, port wake
  always_comb begin
    evt_any = 1'b1;
    evt_full = 1'b0;
    evt_stop = 1'b0;
    evt_cause = reset_cause_pkg::CAUSE_NONE;
    if (ext_fall) begin
      evt_cause = reset_cause_pkg::CAUSE_EXT;
      evt_full = 1'b1;
    end else if (debug_reset_req || (dbg_fall && stop_mode)) begin
      evt_cause = reset_cause_pkg::CAUSE_POWER_ON;
      evt_full = 1'b1;
    end else if (wdt_expire && stop_mode) begin
      evt_cause = reset_cause_pkg::CAUSE_STOP_WDT;
      evt_stop = 1'b1;
    end else if (wdt_expire) begin
      evt_cause = reset_cause_pkg::CAUSE_WDT;
      evt_full = 1'b1;
    end else if (gpio_wake && stop_mode) begin
      evt_cause = reset_cause_pkg::CAUSE_STOP;
      evt_stop = 1'b1;
    end else begin
      evt_any = 1'b0;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.sys_reset = 1'b0;
    st_next.stop_rec = 1'b0;

    // Down counter reloads itself at zero; expiry is the cycle that sees zero
    if (st_reg.wdt_en) begin
      if (st_reg.count == 24'h000000) begin
        st_next.count = st_reg.reload;
      end else begin
        st_next.count = st_reg.count - 24'h000001;
      end
    end

    if (setup_phase && !pwrite) begin
      st_next.rdata = rd_mux;
    end

    if (wr_access) begin
      if (hit_cause) begin
        // Control write: enable bit, and any write refreshes the count
        st_next.wdt_en = pwdata[reset_cause_pkg::CTRL_ENABLE_BIT];
        st_next.count = st_reg.reload;
      end
      if (hit_upper) begin
        st_next.reload[23:16] = pwdata[7:0];
      end
      if (hit_middle) begin
        st_next.reload[15:8] = pwdata[7:0];
      end
      if (hit_lower) begin
        st_next.reload[7:0] = pwdata[7:0];
      end
    end

    // Clear only what was returned; an event landing between setup and access survives
    if (rd_access && hit_cause && (st_reg.cause == st_reg.rdata[7:4])) begin
      st_next.cause = reset_cause_pkg::CAUSE_NONE;
    end

    // Events come last so that they win over the read clear
    if (evt_any) begin
      st_next.cause = evt_cause;
      st_next.count = st_reg.reload;
      st_next.sys_reset = evt_full;
      st_next.stop_rec = evt_stop;
    end
  end

  // The block reset stands for power-on, so the cause comes up as power-on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{cause: reset_cause_pkg::CAUSE_RESET,
                  count: reset_cause_pkg::RELOAD_RESET,
                  reload: reset_cause_pkg::RELOAD_RESET,
                  wdt_en: reset_cause_pkg::CTRL_ENABLE_RESET,
                  rdata: 8'h00,
                  sys_reset: 1'b0,
                  stop_rec: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign system_reset_out = st_reg.sys_reset;
  assign stop_recovery_out = st_reg.stop_rec;
  assign watchdog_expired = wdt_expire;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Event recording
  chk_stop_pin_reset: assert property (
    ext_fall && stop_mode |=> system_reset_out && !stop_recovery_out)
    else $error("pin low in stop did not give a full reset");

  chk_stop_pin_cause: assert property (
    ext_fall && stop_mode |=> st_reg.cause == reset_cause_pkg::CAUSE_EXT)
    else $error("pin low in stop did not record the external flag");

  chk_pin_sets_ext: assert property (
    ext_fall |=> st_reg.cause == reset_cause_pkg::CAUSE_EXT)
    else $error("pin reset did not record external flag only");

  chk_debug_power_on: assert property (
    !ext_fall && (debug_reset_req || (dbg_fall && stop_mode))
    |=> st_reg.cause == reset_cause_pkg::CAUSE_POWER_ON && system_reset_out)
    else $error("debug reset did not record power-on only");

  chk_debug_ignored_run: assert property (
    dbg_fall && !stop_mode && !ext_fall && !debug_reset_req && !wdt_expire
    |=> !system_reset_out && !stop_recovery_out)
    else $error("debug pin acted outside stop");

  chk_wdt_normal: assert property (
    wdt_expire && !stop_mode && !ext_fall && !debug_reset_req
    |=> st_reg.cause == reset_cause_pkg::CAUSE_WDT && system_reset_out)
    else $error("watchdog reset did not record watchdog flag only");

  chk_gpio_stop: assert property (
    gpio_wake && stop_mode && !wdt_expire && !ext_fall && !debug_reset_req && !dbg_fall
    |=> st_reg.cause == reset_cause_pkg::CAUSE_STOP && stop_recovery_out)
    else $error("port wake did not record stop recovery only");

  chk_wake_ignored_run: assert property (
    gpio_wake && !stop_mode && !ext_fall && !debug_reset_req && !wdt_expire
    |=> !system_reset_out && !stop_recovery_out)
    else $error("port wake acted outside stop");

  chk_wdt_stop: assert property (
    wdt_expire && stop_mode && !ext_fall && !debug_reset_req && !dbg_fall
    |=> st_reg.cause == reset_cause_pkg::CAUSE_STOP_WDT && stop_recovery_out && !system_reset_out)
    else $error("watchdog in stop did not record stop and watchdog");

  chk_power_on_drop: assert property (
    st_reg.cause[reset_cause_pkg::POWER_ON_BIT] && wdt_expire && !ext_fall && !debug_reset_req && !dbg_fall
    |=> !st_reg.cause[reset_cause_pkg::POWER_ON_BIT])
    else $error("power-on flag survived a watchdog expiry");

  chk_cause_holds: assert property (
    !evt_any && !rd_access |=> $stable(st_reg.cause))
    else $error("cause flags changed with no event or read");

  // Register bus
  chk_read_clears: assert property (
    setup_phase && !pwrite && hit_cause && !evt_any ##1
    access_phase && !pwrite && hit_cause && !evt_any
    |=> st_reg.cause == reset_cause_pkg::CAUSE_NONE)
    else $error("cause read did not clear flags");

  chk_read_returns: assert property (
    setup_phase && !pwrite && hit_cause
    |=> prdata == {24'h000000, $past(st_reg.cause), 4'h0})
    else $error("cause read returned wrong data");

  chk_event_wins: assert property (
    rd_access && hit_cause && evt_any |=> st_reg.cause == $past(evt_cause))
    else $error("read clear beat a new event");

  chk_write_no_cause: assert property (
    wr_access && hit_cause && !evt_any && !rd_access |=> $stable(st_reg.cause))
    else $error("write at cause address altered the flags");

  chk_ctrl_enable: assert property (
    wr_access && hit_cause |=> st_reg.wdt_en == $past(pwdata[reset_cause_pkg::CTRL_ENABLE_BIT]))
    else $error("control write did not set the watchdog enable");

  chk_unmapped_ignored: assert property (
    access_phase && pwrite && !mapped |=> $stable(st_reg.reload) && $stable(st_reg.wdt_en))
    else $error("write to an unmapped address changed state");

  chk_reload_upper: assert property (
    wr_access && hit_upper |=> st_reg.reload[23:16] == $past(pwdata[7:0]))
    else $error("upper reload byte not written");

  chk_reload_middle: assert property (
    wr_access && hit_middle |=> st_reg.reload[15:8] == $past(pwdata[7:0]))
    else $error("middle reload byte not written");

  chk_reload_lower: assert property (
    wr_access && hit_lower |=> st_reg.reload[7:0] == $past(pwdata[7:0]))
    else $error("lower reload byte not written");

  chk_count_read: assert property (
    setup_phase && !pwrite && hit_lower |=> prdata[7:0] == $past(st_reg.count[7:0]))
    else $error("reload read did not return live count");

  chk_count_read_upper: assert property (
    setup_phase && !pwrite && hit_upper |=> prdata[7:0] == $past(st_reg.count[23:16]))
    else $error("upper reload read did not return live count");

  chk_count_read_middle: assert property (
    setup_phase && !pwrite && hit_middle |=> prdata[7:0] == $past(st_reg.count[15:8]))
    else $error("middle reload read did not return live count");

  chk_reload_read_quiet: assert property (
    rd_access && !hit_cause |=> $stable(st_reg.reload))
    else $error("reload read altered the reload value");

  // Watchdog counter
  chk_wdt_reloads: assert property (
    wdt_expire |=> st_reg.count == $past(st_reg.reload))
    else $error("watchdog did not reload on expiry");

  chk_count_down: assert property (
    st_reg.wdt_en && st_reg.count != 24'h000000 && !evt_any && !(wr_access && hit_cause)
    |=> st_reg.count == $past(st_reg.count) - 24'h000001)
    else $error("watchdog count did not step down");

  cov_pin_reset: cover property (ext_fall ##1 system_reset_out);
  cov_stop_wdt: cover property (wdt_expire && stop_mode ##1 stop_recovery_out);
  cov_read_clear: cover property (rd_access && hit_cause && st_reg.cause != 4'h0);
  cov_event_on_read: cover property (rd_access && hit_cause && evt_any);
  cov_debug_in_stop: cover property (dbg_fall && stop_mode);

endmodule : reset_cause_and_watchdog_reload

// file: tb/reset_source_model.sv
`timescale 1ns/1ps
module reset_source_model (
  input wire logic sys_clk,
  output logic ext_reset_n,
  output logic debug_pin_n,
  output logic debug_reset_req,
  output logic gpio_wake
);
  // Both pins are pulled up, so a released pin reads high
  initial begin
    ext_reset_n = 1'b1;
    debug_pin_n = 1'b1;
    debug_reset_req = 1'b0;
    gpio_wake = 1'b0;
  end

  // Low time is the caller's choice: short lows probe the glitch filter
  task automatic hold_ext(input int cycles);
    ext_reset_n <= 1'b0;
    repeat (cycles) @(posedge sys_clk);
    ext_reset_n <= 1'b1;
  endtask : hold_ext

  task automatic hold_dbg(input int cycles);
    debug_pin_n <= 1'b0;
    repeat (cycles) @(posedge sys_clk);
    debug_pin_n <= 1'b1;
  endtask : hold_dbg

  task automatic req_debug();
    debug_reset_req <= 1'b1;
    @(posedge sys_clk);
    debug_reset_req <= 1'b0;
  endtask : req_debug

  task automatic wake();
    gpio_wake <= 1'b1;
    @(posedge sys_clk);
    gpio_wake <= 1'b0;
  endtask : wake
endmodule : reset_source_model

// file: tb/reset_cause_and_watchdog_reload_test.sv
`timescale 1ns/1ps
`define CHK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", name, exp, got); end end
module reset_cause_and_watchdog_reload_test;
  logic sys_clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic ext_reset_n, debug_pin_n, debug_reset_req, gpio_wake;
  logic stop_mode;
  logic [31:0] rdv;
  logic errv;
  logic system_reset_out, stop_recovery_out, watchdog_expired;
  int error_cnt = 0;
  int n_tests = 0;
  int sys_cnt = 0;
  int stop_cnt = 0;
  int wdt_cnt = 0;
  int s0, t0, w0;

  reset_cause_and_watchdog_reload #(.FILTER_CYCLES(2)) reset_cause_and_watchdog_reload_i (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_n(ext_reset_n),
    .debug_pin_n(debug_pin_n), .debug_reset_req(debug_reset_req), .stop_mode(stop_mode),
    .gpio_wake(gpio_wake), .system_reset_out(system_reset_out), .stop_recovery_out(stop_recovery_out),
    .watchdog_expired(watchdog_expired));

  reset_source_model src_model (.sys_clk(sys_clk), .ext_reset_n(ext_reset_n), .debug_pin_n(debug_pin_n),
    .debug_reset_req(debug_reset_req), .gpio_wake(gpio_wake));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge sys_clk) begin
    if (system_reset_out === 1'b1) sys_cnt++;
    if (stop_recovery_out === 1'b1) stop_cnt++;
    if (watchdog_expired === 1'b1) wdt_cnt++;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // One APB transfer; an idle cycle follows so psel is never driven twice in one step
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(pready === 1'b1) && n < 50);
    if (n >= 50) begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b1, wd, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b0, 8'h00, rd, err);
    `CHK("prdata", {24'h000000, exp}, rd)
    `CHK("pslverr", exp_err, err)
  endtask : rd_chk

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 16'h0000;
    pwdata <= 32'h00000000;
    stop_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wr(12'hff0, 8'h00);
    rd_chk(12'hff0, 8'h80, 1'b0);
    rd_chk(12'hff0, 8'h00, 1'b0);
    rd_chk(12'hff1, 8'h00, 1'b0);
    rd_chk(12'hff2, 8'h04, 1'b0);
    rd_chk(12'hff3, 8'h00, 1'b0);
    wr(12'hff1, 8'h01);
    wr(12'hff2, 8'h23);
    wr(12'hff3, 8'h45);
    wr(12'hff0, 8'h00);
    rd_chk(12'hff1, 8'h01, 1'b0);
    rd_chk(12'hff2, 8'h23, 1'b0);
    rd_chk(12'hff3, 8'h45, 1'b0);
    rd_chk(12'hff0, 8'h00, 1'b0);
    rd_chk(12'hff4, 8'h00, 1'b1);
    apb(12'hff4, 1'b1, 8'hff, rdv, errv);
    `CHK("pslverr", 1'b1, errv)
    src_model.hold_ext(1);
    repeat (10) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h00, 1'b0);
    s0 = sys_cnt;
    src_model.hold_ext(4);
    repeat (10) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h10, 1'b0);
    `CHK("reset pulses", s0 + 1, sys_cnt)
    src_model.req_debug();
    repeat (3) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h80, 1'b0);
    src_model.hold_dbg(4);
    repeat (10) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h00, 1'b0);
    stop_mode <= 1'b1;
    src_model.hold_dbg(4);
    repeat (10) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h80, 1'b0);
    t0 = stop_cnt;
    src_model.wake();
    repeat (3) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h40, 1'b0);
    `CHK("recovery pulses", t0 + 1, stop_cnt)
    // A port wake lands in the access cycle of a cause read
    fork
      rd_chk(12'hff0, 8'h00, 1'b0);
      begin
        @(posedge sys_clk);
        src_model.wake();
      end
    join
    rd_chk(12'hff0, 8'h40, 1'b0);
    s0 = sys_cnt;
    t0 = stop_cnt;
    src_model.hold_ext(4);
    repeat (10) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h10, 1'b0);
    `CHK("reset pulses", s0 + 1, sys_cnt)
    `CHK("recovery pulses", t0, stop_cnt)
    stop_mode <= 1'b0;
    src_model.wake();
    repeat (3) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h00, 1'b0);
    src_model.req_debug();
    w0 = wdt_cnt;
    wr(12'hff1, 8'h00);
    wr(12'hff2, 8'h00);
    wr(12'hff3, 8'h10);
    wr(12'hff0, 8'h01);
    repeat (30) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h20, 1'b0);
    `CHK("watchdog expiries", 1'b1, wdt_cnt > w0)
    t0 = stop_cnt;
    stop_mode <= 1'b1;
    repeat (30) @(posedge sys_clk);
    rd_chk(12'hff0, 8'h60, 1'b0);
    `CHK("recovery pulses", 1'b1, stop_cnt > t0)
    wr(12'hff0, 8'h00);
    w0 = wdt_cnt;
    repeat (40) @(posedge sys_clk);
    `CHK("watchdog expiries", w0, wdt_cnt)
    complete_run();
  end
endmodule : reset_cause_and_watchdog_reload_test
